/* logic/rfc_host_ctrl.v */
// host-side controller for the packet radio's serial command port
// assumes software on a plain strobe port; radio pins are asynchronous to CLOCK
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "rfc_defines.vh"

module rfc_host_ctrl (
	input wire CLOCK,
	input wire RST,
	input wire [7:0] SW_ADDR,
	input wire [31:0] SW_WDATA,
	input wire SW_WR,
	input wire SW_RD,
	output wire [31:0] SW_RDATA,
	output wire SPI_CSN_N,
	output wire SPI_SCK,
	output wire SPI_MOSI,
	input wire SPI_MISO,
	input wire RADIO_IRQ_N,
	output wire RADIO_CE
);

	// ****************************************
	// constants and states
	// ****************************************
	localparam [7:0] SETUP_CYC = `RFC_CSN_SETUP_CYC;
	localparam [7:0] HOLD_CYC = `RFC_CSN_HOLD_CYC;
	localparam [7:0] GAP_CYC = `RFC_CSN_GAP_CYC;
	localparam [2:0] S_IDLE = 3'd0; // chip select high, waiting
	localparam [2:0] S_SETUP = 3'd1; // chip select low, before first edge
	localparam [2:0] S_CMD = 3'd2; // command byte in flight
	localparam [2:0] S_DATA = 3'd3; // data bytes in flight
	localparam [2:0] S_HOLD = 3'd4; // after last edge, before release
	localparam [2:0] S_GAP = 3'd5; // chip select high, minimum idle

	// ****************************************
	// decode helpers
	// ****************************************
	// opcodes whose data bytes come back from the radio
	function is_read;
		input [7:0] op;
		begin
			is_read = (op[7:5] == 3'b000) || (op == `RFC_OP_RX_PAYLOAD) || (op == `RFC_OP_RX_WIDTH);
		end
	endfunction

	// legal opcode, byte count and mode; refused commands never reach the pins
	function cmd_ok;
		input [7:0] op;
		input [5:0] len;
		input ce;
		reg reg_len;
		reg pay_len;
		begin
			reg_len = (len != 6'd0) && (len <= `RFC_MAX_REG_BYTES);
			pay_len = (len != 6'd0) && (len <= `RFC_MAX_PAYLOAD);
			if (op[7:6] == 2'b00) begin // read any time, write only with enable low
				cmd_ok = reg_len && (!op[5] || !ce);
			end else if ((op == `RFC_OP_RX_PAYLOAD) || (op == `RFC_OP_TX_PAYLOAD) ||
				(op == `RFC_OP_TX_NOACK)) begin
				cmd_ok = pay_len;
			end else if (op[7:3] == 5'b10101) begin
				cmd_ok = pay_len && (op[2:0] <= `RFC_MAX_PIPE);
			end else if ((op == `RFC_OP_FLUSH_TX) || (op == `RFC_OP_NOP)) begin
				cmd_ok = (len == 6'd0);
			end else if ((op == `RFC_OP_FLUSH_RX) || (op == `RFC_OP_REUSE)) begin
				cmd_ok = (len == 6'd0) && !ce;
			end else if ((op == `RFC_OP_ACTIVATE) || (op == `RFC_OP_RX_WIDTH)) begin
				cmd_ok = (len == 6'd1);
			end else begin
				cmd_ok = 1'b0;
			end
		end
	endfunction

	// ****************************************
	// state and registers
	// ****************************************
	reg [2:0] state_ff; // sequencer state
	reg [2:0] nxt_state; // next sequencer state
	reg [7:0] cnt_ff; // timing counter for setup, hold, gap
	reg [7:0] op_ff; // latched opcode
	reg [5:0] len_ff; // latched data byte count
	reg rev_ff; // most significant byte first
	reg [5:0] idx_ff; // data byte in flight
	reg csn_ff; // chip select, active low
	reg start_ff; // shifter launch pulse
	reg [7:0] txb_ff; // byte handed to the shifter
	reg ce_ff; // radio enable level
	reg refused_ff; // sticky: a command was refused
	reg stale_ff; // status byte taken across an interrupt edge
	reg [7:0] sbyte_ff; // status byte of the last command
	reg [5:0] txcnt_ff; // bytes loaded into the send buffer
	reg [5:0] rxcnt_ff; // bytes stored into the receive buffer
	reg [5:0] rxptr_ff; // next receive byte to hand to software
	reg irq_d_ff; // delayed synced interrupt, for edge find
	reg [31:0] rdata_ff; // read answer
	reg [7:0] txbuf [0:31]; // outgoing data bytes
	reg [7:0] rxbuf [0:31]; // incoming data bytes

	wire miso_s; // synced data in
	wire irq_s; // synced interrupt, high while the radio pulls its pin low
	wire sh_busy; // shifter busy
	wire sh_done; // shifter finished a byte
	wire [7:0] sh_rx; // byte received
	wire launch; // valid command write while idle
	wire refuse; // command write that is not carried out
	wire last_byte; // byte in flight is the final one
	wire [5:0] pos; // buffer index honouring byte order
	wire [5:0] next_pos; // buffer index of the following byte
	wire irq_fall; // interrupt pin just went low

	// ****************************************
	// pin synchronisers and shifter
	// ****************************************
	rfc_sync #(
		.W(2)
	) u_sync (
		.clk(CLOCK),
		.rst(RST),
		.din({SPI_MISO, ~RADIO_IRQ_N}), // inverted so the reset value matches an idle pin
		.dout({miso_s, irq_s})
	);

	rfc_spi_shift u_shift (
		.clk(CLOCK),
		.rst(RST),
		.start(start_ff),
		.tx_byte(txb_ff),
		.miso_s(miso_s),
		.sck(SPI_SCK),
		.mosi(SPI_MOSI),
		.busy(sh_busy),
		.done(sh_done),
		.rx_byte(sh_rx)
	);

	// ****************************************
	// command acceptance
	// ****************************************
	// only one command at a time; a write while busy counts as refused
	assign launch = SW_WR && (SW_ADDR == `RFC_ADDR_CMD) && (state_ff == S_IDLE) &&
		cmd_ok(SW_WDATA[`RFC_CMD_OP_MSB:`RFC_CMD_OP_LSB],
			SW_WDATA[`RFC_CMD_LEN_MSB:`RFC_CMD_LEN_LSB], ce_ff);
	assign refuse = SW_WR && (SW_ADDR == `RFC_ADDR_CMD) && !launch;
	assign last_byte = (idx_ff + 6'd1 == len_ff);
	// byte order chosen per command: bank-one low registers go msb byte first
	assign pos = rev_ff ? (len_ff - 6'd1 - idx_ff) : idx_ff;
	assign next_pos = rev_ff ? (len_ff - 6'd2 - idx_ff) : (idx_ff + 6'd1);
	assign irq_fall = !irq_d_ff && irq_s;

	// ****************************************
	// sequencer next state
	// ****************************************
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				nxt_state = launch ? S_SETUP : S_IDLE;
			end
			S_SETUP: begin
				nxt_state = (cnt_ff == SETUP_CYC) ? S_CMD : S_SETUP;
			end
			S_CMD: begin // no data: straight to hold
				nxt_state = !sh_done ? S_CMD : (len_ff == 6'd0) ? S_HOLD : S_DATA;
			end
			S_DATA: begin
				nxt_state = (sh_done && last_byte) ? S_HOLD : S_DATA;
			end
			S_HOLD: begin
				nxt_state = (cnt_ff == HOLD_CYC) ? S_GAP : S_HOLD;
			end
			S_GAP: begin
				nxt_state = (cnt_ff == GAP_CYC) ? S_IDLE : S_GAP;
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	// ****************************************
	// sequencer outputs and counters
	// ****************************************
	// chip select falls for every command, so the radio restarts decoding
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_ff <= S_IDLE;
			cnt_ff <= 8'h00;
			op_ff <= 8'h00;
			len_ff <= 6'd0;
			rev_ff <= 1'b0;
			idx_ff <= 6'd0;
			csn_ff <= 1'b1;
			start_ff <= 1'b0;
			txb_ff <= 8'h00;
			sbyte_ff <= `RFC_RST_SBYTE;
			stale_ff <= 1'b0;
			irq_d_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			start_ff <= 1'b0;
			irq_d_ff <= irq_s;
			cnt_ff <= (nxt_state != state_ff) ? 8'h00 : (cnt_ff + 8'h01);
			case (state_ff)
				S_IDLE: begin
					if (launch) begin
						op_ff <= SW_WDATA[`RFC_CMD_OP_MSB:`RFC_CMD_OP_LSB];
						len_ff <= SW_WDATA[`RFC_CMD_LEN_MSB:`RFC_CMD_LEN_LSB];
						rev_ff <= SW_WDATA[`RFC_CMD_REV_BIT];
						idx_ff <= 6'd0;
						csn_ff <= 1'b0;
						stale_ff <= 1'b0;
					end
				end
				S_SETUP: begin // command byte first; start is set on the last setup cycle and pulses in the cycle after it
					txb_ff <= op_ff;
					start_ff <= (cnt_ff == SETUP_CYC);
				end
				S_CMD: begin
					// pipe field may be half-updated across the edge: flag for software
					stale_ff <= stale_ff | irq_fall;
					if (sh_done) begin
						sbyte_ff <= sh_rx;
						if (len_ff != 6'd0) begin // storing starts at byte zero, or at byte len_ff-1 when reversed
							txb_ff <= is_read(op_ff) ? 8'h00 : txbuf[pos[4:0]];
							start_ff <= 1'b1;
						end
					end
				end
				S_DATA: begin
					if (sh_done && !last_byte) begin
						idx_ff <= idx_ff + 6'd1;
						txb_ff <= is_read(op_ff) ? 8'h00 : txbuf[next_pos[4:0]];
						start_ff <= 1'b1;
					end
				end
				S_HOLD: begin // release once the hold time is met
					csn_ff <= csn_ff | (cnt_ff == HOLD_CYC);
				end
				default: begin
					csn_ff <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// data buffers
	// ****************************************
	// no reset on the arrays; contents are only meaningful after a fill
	always @(posedge CLOCK) begin
		if (SW_WR && (SW_ADDR == `RFC_ADDR_TXDATA) && (txcnt_ff < `RFC_MAX_PAYLOAD)) begin
			txbuf[txcnt_ff[4:0]] <= SW_WDATA[7:0];
		end
		if ((state_ff == S_DATA) && sh_done) begin
			rxbuf[pos[4:0]] <= sh_rx;
		end
	end

	// ****************************************
	// software-side counters and flags
	// ****************************************
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			txcnt_ff <= 6'd0;
			rxcnt_ff <= 6'd0;
			rxptr_ff <= 6'd0;
			refused_ff <= 1'b0;
			ce_ff <= `RFC_RST_CE;
		end else begin
			// a 33rd byte is dropped so stored bytes are never overwritten
			if ((state_ff == S_GAP) && (nxt_state == S_IDLE)) begin
				txcnt_ff <= 6'd0;
			end else if (SW_WR && (SW_ADDR == `RFC_ADDR_TXDATA) &&
				(txcnt_ff < `RFC_MAX_PAYLOAD)) begin
				txcnt_ff <= txcnt_ff + 6'd1;
			end
			if (launch) begin
				rxcnt_ff <= 6'd0;
				rxptr_ff <= 6'd0;
			end else begin
				if ((state_ff == S_DATA) && sh_done && is_read(op_ff)) begin
					rxcnt_ff <= rxcnt_ff + 6'd1;
				end
				if (SW_RD && (SW_ADDR == `RFC_ADDR_RXDATA) && (rxptr_ff < rxcnt_ff)) begin
					rxptr_ff <= rxptr_ff + 6'd1;
				end
			end
			// refusal wins over a same-cycle clear
			if (refuse) begin
				refused_ff <= 1'b1;
			end else if (SW_WR && (SW_ADDR == `RFC_ADDR_STATUS) &&
				SW_WDATA[`RFC_ST_REFUSED_BIT]) begin
				refused_ff <= 1'b0;
			end
			if (SW_WR && (SW_ADDR == `RFC_ADDR_CTRL)) begin
				ce_ff <= SW_WDATA[`RFC_CTRL_CE_BIT];
			end
		end
	end

	// ****************************************
	// read port
	// ****************************************
	// answer stands one cycle after the strobe; unmapped addresses read zero
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			rdata_ff <= 32'h00000000;
		end else if (SW_RD) begin
			rdata_ff <= 32'h00000000;
			case (SW_ADDR)
				`RFC_ADDR_STATUS: begin
					rdata_ff[`RFC_ST_BUSY_BIT] <= (state_ff != S_IDLE) || sh_busy;
					rdata_ff[`RFC_ST_REFUSED_BIT] <= refused_ff;
					rdata_ff[`RFC_ST_IRQ_BIT] <= irq_s;
					rdata_ff[`RFC_ST_STALE_BIT] <= stale_ff;
					rdata_ff[`RFC_ST_SBYTE_LSB+7:`RFC_ST_SBYTE_LSB] <= sbyte_ff;
					rdata_ff[`RFC_ST_RXCNT_LSB+5:`RFC_ST_RXCNT_LSB] <= rxcnt_ff;
					rdata_ff[`RFC_ST_TXCNT_LSB+5:`RFC_ST_TXCNT_LSB] <= txcnt_ff;
				end
				`RFC_ADDR_RXDATA: begin
					rdata_ff[7:0] <= rxbuf[rxptr_ff[4:0]];
				end
				`RFC_ADDR_CTRL: begin
					rdata_ff[`RFC_CTRL_CE_BIT] <= ce_ff;
				end
				default: begin // unmapped: stays zero
				end
			endcase
		end else begin
			rdata_ff <= 32'h00000000;
		end
	end

	assign SW_RDATA = rdata_ff;
	assign SPI_CSN_N = csn_ff;
	assign RADIO_CE = ce_ff;

endmodule

/* inc/rfc_defines.vh */
// constants for the radio command controller: register offsets, fields, opcodes, timing
// assumes a 250 MHz system clock and a radio whose serial port runs at 8 MHz at most
`ifndef RFC_DEFINES_VH
`define RFC_DEFINES_VH

// ****************************************
// software register offsets (byte addresses)
// ****************************************
`define RFC_ADDR_CMD 8'h00
`define RFC_ADDR_TXDATA 8'h04
`define RFC_ADDR_STATUS 8'h08
`define RFC_ADDR_RXDATA 8'h0c
`define RFC_ADDR_CTRL 8'h10

// ****************************************
// field positions
// ****************************************
`define RFC_CMD_OP_MSB 7
`define RFC_CMD_OP_LSB 0
`define RFC_CMD_LEN_MSB 13
`define RFC_CMD_LEN_LSB 8
`define RFC_CMD_REV_BIT 14
`define RFC_ST_BUSY_BIT 0
`define RFC_ST_REFUSED_BIT 1
`define RFC_ST_IRQ_BIT 2
`define RFC_ST_STALE_BIT 3
`define RFC_ST_SBYTE_LSB 8
`define RFC_ST_RXCNT_LSB 16
`define RFC_ST_TXCNT_LSB 24
`define RFC_CTRL_CE_BIT 0

// ****************************************
// reset values
// ****************************************
`define RFC_RST_CE 1'b0
`define RFC_RST_SBYTE 8'h00

// ****************************************
// radio opcodes
// ****************************************
`define RFC_OP_RX_PAYLOAD 8'h61
`define RFC_OP_RX_WIDTH 8'h60
`define RFC_OP_TX_PAYLOAD 8'ha0
`define RFC_OP_TX_NOACK 8'hb0
`define RFC_OP_FLUSH_TX 8'he1
`define RFC_OP_FLUSH_RX 8'he2
`define RFC_OP_REUSE 8'he3
`define RFC_OP_ACTIVATE 8'h50
`define RFC_OP_NOP 8'hff
`define RFC_MAX_PAYLOAD 6'd32
`define RFC_MAX_REG_BYTES 6'd5
`define RFC_MAX_PIPE 3'd5

// ****************************************
// timing
// ****************************************
`define RFC_CLK_NS 4
`define RFC_SCK_HALF_NS 63
`define RFC_SCK_HALF_CYC ((`RFC_SCK_HALF_NS + `RFC_CLK_NS - 1) / `RFC_CLK_NS)
`define RFC_CSN_SETUP_NS 2
`define RFC_CSN_SETUP_CYC ((`RFC_CSN_SETUP_NS + `RFC_CLK_NS - 1) / `RFC_CLK_NS)
`define RFC_CSN_HOLD_NS 2
`define RFC_CSN_HOLD_CYC ((`RFC_CSN_HOLD_NS + `RFC_CLK_NS - 1) / `RFC_CLK_NS)
`define RFC_CSN_GAP_NS 50
`define RFC_CSN_GAP_CYC ((`RFC_CSN_GAP_NS + `RFC_CLK_NS - 1) / `RFC_CLK_NS)

`endif

/* logic/rfc_sync.v */
// two-stage synchroniser for the level inputs coming from the radio pins
// assumes the inputs are asynchronous to clk and slow against it
`timescale 1ns/10ps

module rfc_sync #(
	parameter W = 2
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);

	// ****************************************
	// one flop pair per bit
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg meta_ff; // first stage, read only by the second
			reg sync_ff; // second stage, safe to use
			// plain two-flop chain, reset to zero
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					meta_ff <= 1'b0;
					sync_ff <= 1'b0;
				end else begin
					meta_ff <= din[g];
					sync_ff <= meta_ff;
				end
			end
			assign dout[g] = sync_ff;
		end
	endgenerate

endmodule

/* logic/rfc_spi_shift.v */
// one-byte serial shifter, mode 0: data changes with clock low, sampled at clock high
// assumes miso_s is already synchronised; start is honoured only while idle
`timescale 1ns/10ps
`include "rfc_defines.vh"

module rfc_spi_shift (
	input wire clk,
	input wire rst,
	input wire start,
	input wire [7:0] tx_byte,
	input wire miso_s,
	output wire sck,
	output wire mosi,
	output wire busy,
	output wire done,
	output wire [7:0] rx_byte
);

	localparam [7:0] HALF = `RFC_SCK_HALF_CYC; // cycles per half clock period

	reg busy_ff; // byte in flight
	reg done_ff; // one-cycle end pulse
	reg phase_ff; // 0 low half, 1 high half
	reg [7:0] div_ff; // half period counter
	reg [2:0] bit_ff; // bits left minus one
	reg [7:0] sh_ff; // shifts out at msb, in at lsb
	reg sck_ff; // link clock, from the divider
	reg mosi_ff; // data out

	// ****************************************
	// bit engine
	// ****************************************
	// msb goes first; sampling happens at the end of the high half, which leaves
	// a whole half period after the far end's falling-edge update plus sync delay
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			phase_ff <= 1'b0;
			div_ff <= 8'h00;
			bit_ff <= 3'h0;
			sh_ff <= 8'h00;
			sck_ff <= 1'b0;
			mosi_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (!busy_ff) begin
				if (start) begin // load a new byte
					busy_ff <= 1'b1;
					phase_ff <= 1'b0;
					div_ff <= 8'h00;
					bit_ff <= 3'h7;
					sh_ff <= tx_byte;
					mosi_ff <= tx_byte[7];
				end
			end else if (div_ff == HALF - 8'h01) begin
				div_ff <= 8'h00;
				if (!phase_ff) begin // rising edge
					sck_ff <= 1'b1;
					phase_ff <= 1'b1;
				end else begin // falling edge: sample, then next bit
					sck_ff <= 1'b0;
					phase_ff <= 1'b0;
					sh_ff <= {sh_ff[6:0], miso_s};
					mosi_ff <= sh_ff[6];
					if (bit_ff == 3'h0) begin
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
					end else begin
						bit_ff <= bit_ff - 3'h1;
					end
				end
			end else begin
				div_ff <= div_ff + 8'h01;
			end
		end
	end

	assign sck = sck_ff;
	assign mosi = mosi_ff;
	assign busy = busy_ff;
	assign done = done_ff;
	assign rx_byte = sh_ff;

endmodule

/* tb/rfc_host_ctrl_properties.sv */
// checker for the radio command controller pins
// assumes it sees only the top ports; attached by bind below
`timescale 1ns/10ps
`include "rfc_defines.vh"

module rfc_host_ctrl_chk (
	input wire CLOCK,
	input wire RST,
	input wire [7:0] SW_ADDR,
	input wire [31:0] SW_WDATA,
	input wire SW_WR,
	input wire SW_RD,
	input wire [31:0] SW_RDATA,
	input wire SPI_CSN_N,
	input wire SPI_SCK,
	input wire SPI_MOSI,
	input wire SPI_MISO,
	input wire RADIO_IRQ_N,
	input wire RADIO_CE
);
	// ****************************************
	// helper counters
	// ****************************************
	reg sck_q_ff; // last serial clock level
	reg [7:0] hi_cnt_ff; // cycles with serial clock high
	reg [8:0] rise_cnt_ff; // serial clock rises in this frame

	// counters kept apart from the design so a shared slip cannot hide
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sck_q_ff <= 1'b0;
			hi_cnt_ff <= 8'h00;
			rise_cnt_ff <= 9'h000;
		end else begin
			sck_q_ff <= SPI_SCK;
			hi_cnt_ff <= SPI_SCK ? hi_cnt_ff + 8'h01 : 8'h00;
			if (SPI_CSN_N) begin
				rise_cnt_ff <= 9'h000; // frame over, restart
			end else if (SPI_SCK && !sck_q_ff) begin
				rise_cnt_ff <= rise_cnt_ff + 9'h001;
			end
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	// ****************************************
	// properties
	// ****************************************
	a_sck_idle_low: assert property (SPI_CSN_N |-> !SPI_SCK)
		else $error("serial clock high outside a frame");
	a_sck_in_frame: assert property ($rose(SPI_SCK) |-> !$past(SPI_CSN_N))
		else $error("serial clock rose without a prior select");
	a_csn_gap_min: assert property ($rose(SPI_CSN_N) |=> SPI_CSN_N [*8])
		else $error("chip select gap too short");
	a_frame_starts: assert property ($fell(SPI_CSN_N) |-> ##[1:300] $rose(SPI_SCK))
		else $error("no serial clock after select");
	a_mosi_hold_high: assert property ((SPI_SCK && $past(SPI_SCK)) |-> $stable(SPI_MOSI))
		else $error("data moved while serial clock high");
	a_sck_high_time: assert property ($fell(SPI_SCK) |-> hi_cnt_ff == 8'd16)
		else $error("serial clock high time wrong");
	a_whole_bytes: assert property ($rose(SPI_CSN_N) |->
		(rise_cnt_ff[2:0] == 3'd0) && (rise_cnt_ff != 9'd0))
		else $error("frame not a whole number of bytes");
	a_frame_max_len: assert property ($rose(SPI_CSN_N) |-> rise_cnt_ff <= 9'd264)
		else $error("frame longer than command plus 32 bytes");
	a_ce_follows_reg: assert property ((SW_WR && SW_ADDR == `RFC_ADDR_CTRL) |=>
		RADIO_CE == $past(SW_WDATA[0]))
		else $error("enable pin did not follow control write");
	a_rdata_idle_zero: assert property (!$past(SW_RD) |-> SW_RDATA == 32'h0)
		else $error("read data not zero outside read slot");
endmodule

bind rfc_host_ctrl rfc_host_ctrl_chk u_chk (.CLOCK(CLOCK), .RST(RST), .SW_ADDR(SW_ADDR),
	.SW_WDATA(SW_WDATA), .SW_WR(SW_WR), .SW_RD(SW_RD), .SW_RDATA(SW_RDATA),
	.SPI_CSN_N(SPI_CSN_N), .SPI_SCK(SPI_SCK), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO),
	.RADIO_IRQ_N(RADIO_IRQ_N), .RADIO_CE(RADIO_CE));

/* tb/rfc_radio_model.sv */
// behavioural radio: serial command port, flags, queue levels
// assumes mode 0 framing; ev pulses stand for radio-side events
`timescale 1ns/10ps

module rfc_radio_model (
	input wire csn_n,
	input wire sck,
	input wire mosi,
	output reg miso,
	output wire irq_n,
	input wire [2:0] ev
);
	reg [7:0] regs [0:31][0:4]; // register store
	reg [2:0] flags = 3'b000; // rx ready, tx done, retry limit
	reg [1:0] tx_cnt = 2'd0; // queued transmit payloads
	reg [1:0] rx_cnt = 2'd0; // stored receive payloads
	reg reuse = 1'b0; // repeat-last-payload state
	reg [7:0] op, sh, out, nxt;
	reg [2:0] bitn;
	reg [5:0] idx;
	integer i, j;
	wire [7:0] status_b = {1'b0, flags, (rx_cnt == 2'd0) ? 3'b111 : 3'b000, tx_cnt == 2'd3};
	wire [7:0] fifo_b = {1'b0, reuse, tx_cnt == 2'd3, tx_cnt == 2'd0, 2'b00, rx_cnt == 2'd3,
		rx_cnt == 2'd0};

	// pin is the inverted or of unmasked flags
	assign irq_n = ~|(flags & ~regs[0][0][6:4]);

	initial begin
		for (i = 0; i < 32; i = i + 1) begin
			for (j = 0; j < 5; j = j + 1) begin
				regs[i][j] = 8'h00;
			end
		end
		regs[0][0] = 8'h08; // all sources unmasked
		miso = 1'b0;
	end

	// select falling restarts decoding, status goes out first
	always @(negedge csn_n) begin
		bitn = 3'd0;
		idx = 6'd0;
		out = status_b;
		miso = out[7];
	end

	// released line toggles so a stale bit cannot pass
	always @(posedge csn_n) begin
		miso = ~miso;
		if ((op == 8'ha0 || op == 8'hb0 || op[7:3] == 5'h15) && idx > 6'd1) begin
			if (tx_cnt != 2'd3) tx_cnt = tx_cnt + 2'd1;
			reuse = 1'b0;
		end
		if (op == 8'h61 && idx > 6'd1 && rx_cnt != 2'd0) rx_cnt = rx_cnt - 2'd1;
	end

	// radio-side events; retry limit leaves the queue alone
	always @(posedge ev[2]) begin
		flags[2] = 1'b1;
		if (rx_cnt != 2'd3) rx_cnt = rx_cnt + 2'd1;
	end
	always @(posedge ev[1]) flags[1] = 1'b1;
	always @(posedge ev[0]) flags[0] = 1'b1;

	// sample at rise, act on each whole byte
	always @(posedge sck) if (!csn_n) begin
		sh = {sh[6:0], mosi};
		bitn = bitn + 3'd1;
		if (bitn == 3'd0) begin
			if (idx == 6'd0) begin
				op = sh;
				if (op == 8'he1) begin
					tx_cnt = 2'd0;
					reuse = 1'b0;
				end
				if (op == 8'he2) rx_cnt = 2'd0;
				if (op == 8'he3) reuse = 1'b1;
			end else if (op[7:5] == 3'b001) begin
				if (op[4:0] == 5'd7) flags = flags & ~sh[6:4];
				else if (idx < 6'd6) regs[op[4:0]][idx - 6'd1] = sh;
			end
			if (op[7:5] == 3'b000) begin
				nxt = (op[4:0] == 5'h07) ? status_b : (op[4:0] == 5'h17) ? fifo_b :
					regs[op[4:0]][idx];
			end else if (op == 8'h61) begin
				nxt = (rx_cnt != 2'd0) ? 8'h40 + {2'b00, idx} : ~nxt;
			end else begin
				nxt = 8'h00;
			end
			idx = idx + 6'd1;
		end
	end

	// next bit leaves on the fall
	always @(negedge sck) if (!csn_n) begin
		if (bitn == 3'd0) out = nxt;
		miso = out[3'd7 - bitn];
	end
endmodule

/* tb/rfc_host_ctrl_tb_top.sv */
// testbench for the radio command controller
// assumes the radio model in rfc_radio_model and the bound checker
`timescale 1ns/10ps
`include "rfc_defines.vh"

module rfc_host_ctrl_tb_top;
	reg CLOCK = 1'b0;
	reg RST = 1'b1;
	reg [7:0] SW_ADDR = 8'h00;
	reg [31:0] SW_WDATA = 32'h0;
	reg SW_WR = 1'b0;
	reg SW_RD = 1'b0;
	reg [2:0] ev = 3'b000; // radio-side events
	wire [31:0] SW_RDATA;
	wire SPI_CSN_N, SPI_SCK, SPI_MOSI, SPI_MISO, RADIO_IRQ_N, RADIO_CE;
	integer miscompares = 0;
	integer check_count = 0;
	integer i, j, n;
	reg [31:0] d; // last read data
	reg [7:0] v; // running byte value
	reg [14:0] bad [0:5]; // {ce, len, op} of refused commands

	rfc_host_ctrl u_dut (.CLOCK(CLOCK), .RST(RST), .SW_ADDR(SW_ADDR), .SW_WDATA(SW_WDATA),
		.SW_WR(SW_WR), .SW_RD(SW_RD), .SW_RDATA(SW_RDATA), .SPI_CSN_N(SPI_CSN_N),
		.SPI_SCK(SPI_SCK), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO),
		.RADIO_IRQ_N(RADIO_IRQ_N), .RADIO_CE(RADIO_CE));
	rfc_radio_model u_radio (.csn_n(SPI_CSN_N), .sck(SPI_SCK), .mosi(SPI_MOSI),
		.miso(SPI_MISO), .irq_n(RADIO_IRQ_N), .ev(ev));

	// ****************************************
	// access tasks
	// ****************************************
	initial begin
		forever #2 CLOCK = ~CLOCK;
	end

	task sw_write(input [7:0] a, input [31:0] val);
		begin
			@(posedge CLOCK);
			SW_ADDR <= a;
			SW_WDATA <= val;
			SW_WR <= 1'b1;
			@(posedge CLOCK);
			SW_WR <= 1'b0;
		end
	endtask

	// data stands only in the cycle after the strobe
	task sw_read(input [7:0] a);
		begin
			@(posedge CLOCK);
			SW_ADDR <= a;
			SW_RD <= 1'b1;
			@(posedge CLOCK);
			SW_RD <= 1'b0;
			#1 d = SW_RDATA;
		end
	endtask

	task chk(input [8*12-1:0] what, input [7:0] seen, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("ERROR %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	// launch and poll busy, bounded
	task cmd(input [7:0] op, input [5:0] len, input rev);
		begin
			sw_write(`RFC_ADDR_CMD, {17'h0, rev, len, op});
			n = 0;
			sw_read(`RFC_ADDR_STATUS);
			while (d[0] !== 1'b0 && n < 9000) begin
				sw_read(`RFC_ADDR_STATUS);
				n = n + 1;
			end
			if (n == 9000) chk("busy", 8'h01, 8'h00);
		end
	endtask

	task load(input [7:0] first, input [5:0] len, input [7:0] step);
		begin
			v = first;
			for (j = 0; j < len; j = j + 1) begin
				sw_write(`RFC_ADDR_TXDATA, {24'h0, v});
				v = v + step;
			end
		end
	endtask

	task rd_cmp(input [7:0] first, input [5:0] len, input [7:0] step);
		begin
			v = first;
			for (j = 0; j < len; j = j + 1) begin
				sw_read(`RFC_ADDR_RXDATA);
				chk("rx byte", d[7:0], v);
				v = v + step;
			end
		end
	endtask

	task fifo_chk(input [7:0] exp);
		begin
			cmd(8'h17, 6'd1, 1'b0);
			sw_read(`RFC_ADDR_RXDATA);
			chk("fifo status", d[7:0], exp);
		end
	endtask

	task irq_chk(input [7:0] exp);
		begin
			sw_read(`RFC_ADDR_STATUS);
			chk("irq", {7'h0, d[2]}, exp);
		end
	endtask

	// event pulse, then room for the two-flop sync
	task raise(input [2:0] e);
		begin
			@(posedge CLOCK);
			ev <= e;
			@(posedge CLOCK);
			ev <= 3'b000;
			repeat (4) @(posedge CLOCK);
		end
	endtask

	task summarize;
		begin
			$display("checks %0d miscompares %0d", check_count, miscompares);
			if (miscompares == 0 && check_count > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	// watchdog well beyond the expected run
	initial begin
		#250000;
		miscompares = miscompares + 1;
		$display("ERROR watchdog expected done seen timeout");
		summarize;
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		bad[0] = {1'b1, 6'd1, 8'h25};
		bad[1] = {1'b1, 6'd0, 8'he2};
		bad[2] = {1'b1, 6'd0, 8'he3};
		bad[3] = {1'b0, 6'd0, 8'ha0};
		bad[4] = {1'b0, 6'd33, 8'ha0};
		bad[5] = {1'b0, 6'd1, 8'hae};
		repeat (20) @(posedge CLOCK);
		RST <= 1'b0;
		cmd(`RFC_OP_NOP, 6'd0, 1'b0);
		sw_read(`RFC_ADDR_STATUS);
		chk("status byte", d[15:8], 8'h0e);
		load(8'h11, 6'd5, 8'h01);
		cmd(8'h2a, 6'd5, 1'b0);
		cmd(8'h0a, 6'd5, 1'b0);
		rd_cmp(8'h11, 6'd5, 8'h01);
		load(8'h21, 6'd2, 8'h01);
		cmd(8'h23, 6'd2, 1'b1);
		cmd(8'h03, 6'd2, 1'b0);
		rd_cmp(8'h22, 6'd2, 8'hff);
		// refusals: guarded ops with enable high, bad lengths, bad pipe
		for (i = 0; i < 6; i = i + 1) begin
			sw_write(`RFC_ADDR_CTRL, {31'h0, bad[i][14]});
			#1;
			chk("ce pin", {7'h0, RADIO_CE}, {7'h0, bad[i][14]});
			cmd(bad[i][7:0], bad[i][13:8], 1'b0);
			sw_read(`RFC_ADDR_STATUS);
			chk("refused", {7'h0, d[1]}, 8'h01);
			sw_write(`RFC_ADDR_STATUS, 32'h2);
		end
		chk("reg kept", u_radio.regs[5][0], 8'h00);
		// fourth payload meets a full queue
		for (i = 0; i < 4; i = i + 1) begin
			load(8'h80, 6'd32, 8'h01);
			cmd((i == 1) ? 8'hb0 : (i == 2) ? 8'ha8 : 8'ha0, 6'd32, 1'b0);
		end
		fifo_chk(8'h21);
		cmd(`RFC_OP_REUSE, 6'd0, 1'b0);
		raise(3'b001);
		fifo_chk(8'h61);
		irq_chk(8'h01);
		load(8'h18, 6'd1, 8'h00);
		cmd(8'h20, 6'd1, 1'b0);
		irq_chk(8'h00);
		load(8'h08, 6'd1, 8'h00);
		cmd(8'h20, 6'd1, 1'b0);
		irq_chk(8'h01);
		load(8'h10, 6'd1, 8'h00);
		cmd(8'h27, 6'd1, 1'b0);
		irq_chk(8'h00);
		cmd(`RFC_OP_FLUSH_TX, 6'd0, 1'b0);
		fifo_chk(8'h11);
		raise(3'b100);
		cmd(`RFC_OP_RX_PAYLOAD, 6'd4, 1'b0);
		rd_cmp(8'h40, 6'd4, 8'h01);
		fifo_chk(8'h11);
		// one-byte feature commands: accepted, and the width read gives zero
		load(8'h73, 6'd1, 8'h00);
		cmd(`RFC_OP_ACTIVATE, 6'd1, 1'b0);
		cmd(`RFC_OP_RX_WIDTH, 6'd1, 1'b0);
		rd_cmp(8'h00, 6'd1, 8'h00);
		sw_read(`RFC_ADDR_STATUS);
		chk("refused", {7'h0, d[1]}, 8'h00);
		summarize;
	end
endmodule
